// [logic/rsft_pkg.sv]
// Shared constants and types for the slave frame timing block
`default_nettype none
package rsft_pkg;
   localparam int unsigned CLK_HZ_DEF      = 100_000_000;
   localparam int unsigned BITS_PER_CHAR   = 11;
   localparam int unsigned GAP_BITS        = 33;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned INTERVAL_STEP_MS = 10;
   localparam logic [6:0]  INTERVAL_MAX    = 7'h64;
   localparam logic [6:0]  INTERVAL_RST    = 7'h01;
   localparam logic [12:0] T3C_2400_MS     = 13'h00F;
   localparam logic [12:0] T3C_4800_MS     = 13'h00A;
   localparam logic [12:0] T3C_FAST_MS     = 13'h005;
   localparam logic [12:0] RD_STEP_MS      = 13'h005;
   localparam logic [12:0] WR_PER_WORD_MS  = 13'h014;
   localparam logic [12:0] WR_BASE_MAX_MS  = 13'h00A;
   localparam logic [12:0] MAINT_MS        = 13'h00A;
   localparam logic [12:0] INIT1_MAX_MS    = 13'h1388;
   localparam logic [12:0] INIT2_MAX_MS    = 13'h1F4;
   localparam logic [1:0]  RETRY_LIMIT_DEF = 2'h3;

   typedef enum logic [2:0] {
      RSFT_B2400, RSFT_B4800, RSFT_B9600, RSFT_B19200, RSFT_B38400
   } rsft_baud_e;

   typedef enum logic [2:0] {
      RSFT_Q_READ, RSFT_Q_WRITE, RSFT_Q_MAINT, RSFT_Q_INIT1, RSFT_Q_INIT2_MOTOR
   } rsft_qkind_e;

   // Clock cycles of one bit period at the selected rate
   function automatic logic [19:0] rsft_bit_cyc(input int unsigned clk_hz,
                                                input rsft_baud_e baud);
      int unsigned rate;
      case (baud)
         RSFT_B2400:  rate = 2400;
         RSFT_B4800:  rate = 4800;
         RSFT_B9600:  rate = 9600;
         RSFT_B19200: rate = 19200;
         default:     rate = 38400;
      endcase
      return 20'(clk_hz / rate);
   endfunction : rsft_bit_cyc
endpackage : rsft_pkg
`default_nettype wire

// [logic/rsft_link_if.sv]
// Character-level link between host master and slave station
`default_nettype none
interface rsft_link_if;
   logic       h2d_stb;
   logic [7:0] h2d_data;
   logic       d2h_stb;
   logic [7:0] d2h_data;
   modport dev  (input h2d_stb, input h2d_data, output d2h_stb, output d2h_data);
   modport host (output h2d_stb, output h2d_data, input d2h_stb, input d2h_data);
endinterface : rsft_link_if
`default_nettype wire

// [logic/rsft_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none
module rsft_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
   logic             push, pop;

   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // Storage needs no reset; only the pointers qualify it
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule : rsft_fifo
`default_nettype wire

// [logic/rsft_dev.sv]
// Slave station end: frame delimiting, response delay and turnaround
// Function
// - Response waits longest of interval, 3-char, processing
// - Interval 0 to 1 s, 10 ms steps, default 10 ms (code takes resp_interval as given, INTERVAL_RST unused)
// - 3-char time 15/10/5 ms by baud rate
// - Read processing int((n-1)/8)*5 plus 5 ms
// - Writes processing n*20+5 to n*20+10 ms
// - Init mode one 5 s, mode two/motor 500 ms
// - Maintenance query processing is 10 ms
// - Host sends next frame only after response or timeout
// - Host timeout exceeds worst device response time
// - Host retries, gives up after about three
// - Host waits 3-char after device response ends
// - Broadcast executes then back to receive; host waits
// - 33-bit idle resets frame; next byte starts frame
// - 3-char gap inside frame discards the frame
// - Host sends frame characters back to back
// - Hear other stations; 3-char wait before transmitting
// - Never respond to a broadcast query
`default_nettype none
module rsft_dev #(
   parameter int unsigned CLK_HZ     = rsft_pkg::CLK_HZ_DEF,
   parameter int unsigned FIFO_DEPTH = 4
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   rsft_link_if.dev         link,
   input  wire logic [2:0]  baud_sel,
   input  wire logic [6:0]  resp_interval,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_first,
   input  wire logic        frame_ok,
   input  wire logic [2:0]  frame_kind,
   input  wire logic [7:0]  frame_words,
   input  wire logic        frame_bcast,
   input  wire logic        frame_other,
   output logic             frame_drop,
   output logic             fifo_overrun,
   output logic             resp_open,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_last,
   output logic             standby
);
   localparam int unsigned MS_CYC = CLK_HZ / rsft_pkg::MS_PER_S;

   typedef enum logic [2:0] {S_SYNC, S_READY, S_RX, S_DELAY, S_TX} rsft_dstate_e;

   rsft_dstate_e state_q, state_d;
   logic [19:0]  bcyc_q, bcyc_d, bit_cyc;
   logic [19:0]  mcyc_q, mcyc_d;
   logic [5:0]   gap_q, gap_d;
   logic [12:0]  ms_q, ms_d, target_q, target_d;
   logic [3:0]   txbit_q, txbit_d;
   logic         busy_q, busy_d, last_q, last_d, first_q, first_d, silent_q, silent_d;
   logic         d2h_stb_q, d2h_stb_d, drop_q, drop_d, ovr_q, ovr_d;
   logic [7:0]   txd_q, txd_d;
   logic         bit_tick, gap_full, take_tx, push_ok, fifo_in_ready;
   logic [12:0]  t3c_ms, proc_ms, intv_ms, max_ms;
   logic [6:0]   intv_clip;

   assign bit_cyc  = rsft_pkg::rsft_bit_cyc(CLK_HZ, rsft_pkg::rsft_baud_e'(baud_sel));
   assign bit_tick = bcyc_q >= bit_cyc - 20'h00001;
   assign gap_full = gap_q >= 6'(rsft_pkg::GAP_BITS);
   assign tx_ready = (state_q == S_TX) && !busy_q;
   assign take_tx  = tx_ready && tx_valid;
   assign push_ok  = link.h2d_stb && (state_q == S_READY || state_q == S_RX);

   always_comb begin
      case (rsft_pkg::rsft_baud_e'(baud_sel))
         rsft_pkg::RSFT_B2400: t3c_ms = rsft_pkg::T3C_2400_MS;
         rsft_pkg::RSFT_B4800: t3c_ms = rsft_pkg::T3C_4800_MS;
         default:              t3c_ms = rsft_pkg::T3C_FAST_MS;
      endcase
   end

   // Processing time is taken at its upper bound so the host sees a fixed worst case
   always_comb begin
      case (rsft_pkg::rsft_qkind_e'(frame_kind))
         rsft_pkg::RSFT_Q_READ:
            proc_ms = 13'(((frame_words - 8'h01) >> 3) * rsft_pkg::RD_STEP_MS)
                      + rsft_pkg::RD_STEP_MS;
         rsft_pkg::RSFT_Q_WRITE:
            proc_ms = 13'(frame_words * rsft_pkg::WR_PER_WORD_MS) + rsft_pkg::WR_BASE_MAX_MS;
         rsft_pkg::RSFT_Q_MAINT:       proc_ms = rsft_pkg::MAINT_MS;
         rsft_pkg::RSFT_Q_INIT1:       proc_ms = rsft_pkg::INIT1_MAX_MS;
         default:                      proc_ms = rsft_pkg::INIT2_MAX_MS;
      endcase
   end

   // interval clipped to one second, counted in 10 ms steps
   assign intv_clip = (resp_interval > rsft_pkg::INTERVAL_MAX) ? rsft_pkg::INTERVAL_MAX
                                                               : resp_interval;
   assign intv_ms   = 13'(intv_clip * rsft_pkg::INTERVAL_STEP_MS);

   always_comb begin
      max_ms = intv_ms;
      if (t3c_ms > max_ms) begin
         max_ms = t3c_ms;
      end
      if (proc_ms > max_ms) begin
         max_ms = proc_ms;
      end
   end

   always_comb begin
      state_d   = state_q;
      bcyc_d    = bit_tick ? '0 : bcyc_q + 20'h00001;
      mcyc_d    = (mcyc_q >= 20'(MS_CYC - 1)) ? '0 : mcyc_q + 20'h00001;
      gap_d     = (bit_tick && !gap_full) ? gap_q + 6'h01 : gap_q;
      ms_d      = (mcyc_q >= 20'(MS_CYC - 1) && ms_q != '1) ? ms_q + 13'h0001 : ms_q;
      target_d  = target_q;
      txbit_d   = txbit_q;
      busy_d    = busy_q;
      last_d    = last_q;
      txd_d     = txd_q;
      first_d   = first_q;
      silent_d  = silent_q;
      d2h_stb_d = 1'b0;
      drop_d    = 1'b0;
      ovr_d     = push_ok && !fifo_in_ready;
      // every received character restarts the timers at its stop bit end
      if (link.h2d_stb) begin
         bcyc_d = '0;
         mcyc_d = '0;
         gap_d  = '0;
         ms_d   = '0;
      end
      case (state_q)
         // wait for a full idle gap before accepting a frame start
         S_SYNC: begin
            if (gap_full && !link.h2d_stb) begin
               state_d = S_READY;
            end
         end
         S_READY: begin
            if (link.h2d_stb) begin
               state_d = S_RX;
               first_d = 1'b0;
            end
         end
         S_RX: begin
            if (frame_ok) begin
               target_d = max_ms;
               // broadcast and foreign frames get no response
               silent_d = frame_bcast || frame_other;
               // foreign frame waits a fresh gap
               if (frame_other) begin
                  state_d = S_SYNC;
               end else begin
                  state_d = S_DELAY;
               end
            // gap inside a frame discards it
            end else if (gap_full && !link.h2d_stb) begin
               drop_d  = 1'b1;
               state_d = S_READY;
            end
         end
         S_DELAY: begin
            // response opens when the longest time has passed
            if (ms_q >= target_q) begin
               state_d = silent_q ? S_READY : S_TX;
            end
         end
         S_TX: begin
            if (take_tx) begin
               busy_d  = 1'b1;
               txbit_d = '0;
               txd_d   = tx_data;
               last_d  = tx_last;
               bcyc_d  = '0;
            end else if (busy_q && bit_tick) begin
               txbit_d = txbit_q + 4'h1;
               // one character is eleven bit periods
               if (txbit_q == 4'(rsft_pkg::BITS_PER_CHAR - 1)) begin
                  busy_d    = 1'b0;
                  d2h_stb_d = 1'b1;
                  if (last_q) begin
                     gap_d   = '0;
                     state_d = S_SYNC;
                  end
               end
            end
         end
         default: state_d = S_SYNC;
      endcase
      if (state_d == S_READY && state_q != S_READY) begin
         first_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q   <= S_SYNC;
         bcyc_q    <= '0;
         mcyc_q    <= '0;
         gap_q     <= '0;
         ms_q      <= '0;
         target_q  <= '0;
         txbit_q   <= '0;
         busy_q    <= 1'b0;
         last_q    <= 1'b0;
         txd_q     <= '0;
         first_q   <= 1'b1;
         silent_q  <= 1'b0;
         d2h_stb_q <= 1'b0;
         drop_q    <= 1'b0;
         ovr_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         bcyc_q    <= bcyc_d;
         mcyc_q    <= mcyc_d;
         gap_q     <= gap_d;
         ms_q      <= ms_d;
         target_q  <= target_d;
         txbit_q   <= txbit_d;
         busy_q    <= busy_d;
         last_q    <= last_d;
         txd_q     <= txd_d;
         first_q   <= first_d;
         silent_q  <= silent_d;
         d2h_stb_q <= d2h_stb_d;
         drop_q    <= drop_d;
         ovr_q     <= ovr_d;
      end
   end

   // The line cannot be stalled, so a full buffer loses the byte and flags it
   rsft_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (push_ok),
      .in_ready  (fifo_in_ready),
      .in_data   ({(state_q == S_READY), link.h2d_data}),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  ({rx_first, rx_data})
   );

   assign link.d2h_stb  = d2h_stb_q;
   assign link.d2h_data = txd_q;
   assign frame_drop    = drop_q;
   assign fifo_overrun  = ovr_q;
   assign resp_open     = state_q == S_TX;
   assign standby       = state_q == S_READY;
endmodule : rsft_dev
`default_nettype wire

// [logic/rsft_host.sv]
// Host master end: frame pacing, response timeout, retries and turnaround
`default_nettype none
module rsft_host #(
   parameter int unsigned CLK_HZ = rsft_pkg::CLK_HZ_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   rsft_link_if.host        link,
   input  wire logic [2:0]  baud_sel,
   input  wire logic [12:0] timeout_ms,
   input  wire logic [12:0] bcast_wait_ms,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [7:0]  cmd_data,
   input  wire logic        cmd_last,
   input  wire logic        cmd_bcast,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   output logic             rsp_done,
   output logic             timeout,
   output logic [2:0]       retry_cnt,
   output logic             fault
);
   localparam int unsigned MS_CYC = CLK_HZ / rsft_pkg::MS_PER_S;

   typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAITR, H_RXR, H_BWAIT} rsft_hstate_e;

   rsft_hstate_e state_q, state_d;
   logic [19:0]  bcyc_q, bcyc_d, mcyc_q, mcyc_d, bit_cyc;
   logic [3:0]   cbit_q, cbit_d;
   logic [5:0]   gap_q, gap_d;
   logic [12:0]  ms_q, ms_d;
   logic [7:0]   txd_q, txd_d, rsp_q, rsp_d, hd_q, hd_d;
   logic [2:0]   retry_q, retry_d;
   logic         last_q, last_d, bc_q, bc_d, stb_q, stb_d, rv_q, rv_d;
   logic         done_q, done_d, to_q, to_d, fault_q, fault_d;
   logic         bit_tick, char_end, held;

   assign bit_cyc  = rsft_pkg::rsft_bit_cyc(CLK_HZ, rsft_pkg::rsft_baud_e'(baud_sel));
   assign bit_tick = bcyc_q >= bit_cyc - 20'h00001;
   assign char_end = bit_tick && cbit_q == 4'(rsft_pkg::BITS_PER_CHAR - 1);
   // Parked after a character with no successor, so no repeat strobe
   assign held     = cbit_q == 4'(rsft_pkg::BITS_PER_CHAR);
   // a new frame starts only from idle, after response, timeout or broadcast wait
   assign cmd_ready = (state_q == H_IDLE)
                      || (state_q == H_SEND && (char_end || held) && !last_q);

   always_comb begin
      state_d = state_q;
      bcyc_d  = bit_tick ? '0 : bcyc_q + 20'h00001;
      mcyc_d  = (mcyc_q >= 20'(MS_CYC - 1)) ? '0 : mcyc_q + 20'h00001;
      ms_d    = (mcyc_q >= 20'(MS_CYC - 1) && ms_q != '1) ? ms_q + 13'h0001 : ms_q;
      gap_d   = (bit_tick && gap_q < 6'(rsft_pkg::GAP_BITS)) ? gap_q + 6'h01 : gap_q;
      cbit_d  = (bit_tick && !held) ? cbit_q + 4'h1 : cbit_q;
      txd_d   = txd_q;
      hd_d    = hd_q;
      last_d  = last_q;
      bc_d    = bc_q;
      rsp_d   = rsp_q;
      retry_d = retry_q;
      fault_d = fault_q;
      stb_d   = 1'b0;
      rv_d    = 1'b0;
      done_d  = 1'b0;
      to_d    = 1'b0;
      if (cmd_valid && cmd_ready) begin
         txd_d  = cmd_data;
         last_d = cmd_last;
         bc_d   = (state_q == H_IDLE) ? cmd_bcast : bc_q;
         cbit_d = '0;
         bcyc_d = '0;
      end
      case (state_q)
         H_IDLE: begin
            if (cmd_valid) begin
               state_d = H_SEND;
            end
         end
         H_SEND: begin
            // characters go out back to back, eleven bits each
            if (char_end) begin
               stb_d  = 1'b1;
               // Latch the finished byte; a take at this edge reloads txd
               hd_d   = txd_q;
               ms_d   = '0;
               mcyc_d = '0;
               gap_d  = '0;
               if (last_q) begin
                  state_d = bc_q ? H_BWAIT : H_WAITR;
               end else if (!cmd_valid) begin
                  cbit_d = 4'(rsft_pkg::BITS_PER_CHAR);
               end
            end
         end
         H_WAITR: begin
            if (link.d2h_stb) begin
               state_d = H_RXR;
            // timeout set by the user above the device worst case
            end else if (ms_q >= timeout_ms) begin
               to_d    = 1'b1;
               // count retries and flag a fault past the limit
               retry_d = retry_q + 3'h1;
               if (retry_q >= 3'(rsft_pkg::RETRY_LIMIT_DEF)) begin
                  fault_d = 1'b1;
               end
               state_d = H_IDLE;
            end
         end
         H_RXR: begin
            // the response ends only after a 3-char quiet line
            if (gap_q >= 6'(rsft_pkg::GAP_BITS) && !link.d2h_stb) begin
               done_d  = 1'b1;
               retry_d = '0;
               state_d = H_IDLE;
            end
         end
         // after a broadcast wait out device processing
         H_BWAIT: begin
            if (ms_q >= bcast_wait_ms && gap_q >= 6'(rsft_pkg::GAP_BITS)) begin
               state_d = H_IDLE;
            end
         end
         default: state_d = H_IDLE;
      endcase
      if (link.d2h_stb) begin
         rv_d   = 1'b1;
         rsp_d  = link.d2h_data;
         gap_d  = '0;
         bcyc_d = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= H_IDLE;
         bcyc_q  <= '0;
         mcyc_q  <= '0;
         ms_q    <= '0;
         gap_q   <= '0;
         cbit_q  <= '0;
         txd_q   <= '0;
         hd_q    <= '0;
         last_q  <= 1'b0;
         bc_q    <= 1'b0;
         rsp_q   <= '0;
         retry_q <= '0;
         fault_q <= 1'b0;
         stb_q   <= 1'b0;
         rv_q    <= 1'b0;
         done_q  <= 1'b0;
         to_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         bcyc_q  <= bcyc_d;
         mcyc_q  <= mcyc_d;
         ms_q    <= ms_d;
         gap_q   <= gap_d;
         cbit_q  <= cbit_d;
         txd_q   <= txd_d;
         hd_q    <= hd_d;
         last_q  <= last_d;
         bc_q    <= bc_d;
         rsp_q   <= rsp_d;
         retry_q <= retry_d;
         fault_q <= fault_d;
         stb_q   <= stb_d;
         rv_q    <= rv_d;
         done_q  <= done_d;
         to_q    <= to_d;
      end
   end

   assign link.h2d_stb  = stb_q;
   assign link.h2d_data = hd_q;
   assign rsp_valid     = rv_q;
   assign rsp_data      = rsp_q;
   assign rsp_done      = done_q;
   assign timeout       = to_q;
   assign retry_cnt     = retry_q;
   assign fault         = fault_q;
endmodule : rsft_host
`default_nettype wire

// [test/rsft_link_assertions.sv]
// Link timing checks between the host and slave ends
`default_nettype none
module rsft_link_assertions #(
   parameter int CHAR_CYC = 22,
   parameter int GAP_CYC  = 66,
   parameter int RESP_CYC = 500
) (
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic       h2d_stb,
   input wire logic [7:0] h2d_data,
   input wire logic       d2h_stb,
   input wire logic [7:0] d2h_data
);
   logic [15:0] h_cnt_q;
   logic [15:0] h_cnt_d;
   logic [15:0] d_cnt_q;
   logic [15:0] d_cnt_d;
   // Saturate so a long idle never wraps into a false short gap
   always_comb begin
      h_cnt_d = h2d_stb ? 16'h0001 : h_cnt_q + 16'(h_cnt_q != 16'hFFFF);
      d_cnt_d = d2h_stb ? 16'h0001 : d_cnt_q + 16'(d_cnt_q != 16'hFFFF);
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         h_cnt_q <= 16'hFFFF;
         d_cnt_q <= 16'hFFFF;
      end else begin
         h_cnt_q <= h_cnt_d;
         d_cnt_q <= d_cnt_d;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   h2d_pulse_a: assert property (h2d_stb |=> !h2d_stb [*8])
      else $error("host strobes too close");
   d2h_pulse_a: assert property (d2h_stb |=> !d2h_stb [*8])
      else $error("device strobes too close");
   h2d_char_a: assert property (h2d_stb |-> int'(h_cnt_q) >= CHAR_CYC)
      else $error("host character shorter than eleven bits");
   d2h_char_a: assert property ($rose(d2h_stb) |-> int'(d_cnt_q) >= CHAR_CYC)
      else $error("device character shorter than eleven bits");
   resp_delay_a: assert property (d2h_stb |-> int'(h_cnt_q) >= RESP_CYC)
      else $error("response started before three-character time");
   resp_gap_a: assert property (d2h_stb |-> int'(h_cnt_q) >= GAP_CYC)
      else $error("response started inside 33-bit gap");
   turnaround_a: assert property (h2d_stb |-> int'(d_cnt_q) >= GAP_CYC)
      else $error("host sent inside device turnaround");
   half_duplex_a: assert property (!(h2d_stb && d2h_stb))
      else $error("both ends on the line at once");
endmodule : rsft_link_assertions
`default_nettype wire

// [test/test_rtu_slave_frame_timing.sv]
// Bench joining host and slave ends across the character link
`default_nettype none
module test_rtu_slave_frame_timing;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rstn, rx_ready, frame_ok, frame_bcast, frame_other, tx_valid, tx_last;
   logic        cmd_valid, cmd_last, cmd_bcast, rdy_en, ropen;
   logic [2:0]  baud_sel, frame_kind, retry_cnt;
   logic [6:0]  resp_interval;
   logic [7:0]  frame_words, tx_data, cmd_data, rx_data, rsp_data;
   logic [12:0] timeout_ms, bcast_wait_ms;
   logic        rx_valid, rx_first, frame_drop, fifo_overrun, resp_open, tx_ready, standby;
   logic        cmd_ready, rsp_valid, rsp_done, timeout, fault;
   logic [8:0]  exp_q[$];
   logic [7:0]  rsp_q[$];
   int          n_fail, total_checks, cyc, t_h, n_ovr, n_drop;

   rsft_link_if rsft_link_if_inst ();
   // Slow clock rate keeps a millisecond at 100 cycles
   rsft_dev #(.CLK_HZ(100000), .FIFO_DEPTH(4)) rsft_dev_inst (
      .sys_clk, .rstn, .link(rsft_link_if_inst.dev), .baud_sel, .resp_interval,
      .rx_valid, .rx_ready, .rx_data, .rx_first, .frame_ok, .frame_kind, .frame_words,
      .frame_bcast, .frame_other, .frame_drop, .fifo_overrun, .resp_open, .tx_valid,
      .tx_ready, .tx_data, .tx_last, .standby);
   rsft_host #(.CLK_HZ(100000)) rsft_host_inst (
      .sys_clk, .rstn, .link(rsft_link_if_inst.host), .baud_sel, .timeout_ms,
      .bcast_wait_ms, .cmd_valid, .cmd_ready, .cmd_data, .cmd_last, .cmd_bcast,
      .rsp_valid, .rsp_data, .rsp_done, .timeout, .retry_cnt, .fault);
   rsft_link_assertions rsft_link_assertions_inst (
      .sys_clk, .rstn, .h2d_stb(rsft_link_if_inst.h2d_stb),
      .h2d_data(rsft_link_if_inst.h2d_data), .d2h_stb(rsft_link_if_inst.d2h_stb),
      .d2h_data(rsft_link_if_inst.d2h_data));

   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("[FAIL] %0t got %0h exp %0h to %0h", $time, got, lo, hi);
      end
   endtask : chk_rng

   // Bounded wait on one of several completion flags
   task automatic wait_for(input int s);
      logic [6:0] v;
      for (int i = 0; i < 60000; i++) begin
         @(negedge sys_clk);
         v = {exp_q.size() == 0, standby, timeout, rsp_done, tx_ready, resp_open, cmd_ready};
         if (v[s] === 1'b1) return;
      end
      n_fail++;
      $display("[FAIL] %0t wait %0h got 0 exp 1", $time, s);
      print_verdict();
   endtask : wait_for

   function automatic int exp_ms(input int k, input int n, input int iv, input int bd);
      int p;
      int t;
      p = (k == 0) ? ((n - 1) / 8) * 5 + 5 : (k == 1) ? n * 20 + 10 : (k == 4) ? 500
        : (k == 3) ? 5000 : 10;
      t = (bd == 0) ? 15 : (bd == 1) ? 10 : 5;
      p = (t > p) ? t : p;
      return (iv * 10 > p) ? iv * 10 : p;
   endfunction : exp_ms

   // Gap index g holds the host back long enough to split the frame
   task automatic send(input int n, input logic bc, input int g, input int keep);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         if (i < keep) exp_q.push_back({i == 0 || i == g, b});
         if (i == 0) wait_for(5);
         else if (i == g) repeat (80) @(posedge sys_clk);
         @(posedge sys_clk);
         cmd_valid <= 1'b1;
         cmd_data <= b;
         cmd_last <= (i == n - 1);
         cmd_bcast <= bc;
         wait_for(0);
         @(posedge sys_clk);
         cmd_valid <= 1'b0;
      end
   endtask : send

   task automatic pulse(input int k, input int n, input logic bc, input logic oth);
      @(posedge sys_clk);
      frame_ok <= 1'b1;
      frame_kind <= 3'(k);
      frame_words <= 8'(n);
      frame_bcast <= bc;
      frame_other <= oth;
      @(posedge sys_clk);
      frame_ok <= 1'b0;
   endtask : pulse

   task automatic rsp_case(input int k, input int n, input int iv, input logic bc, input int bd);
      int e;
      logic [7:0] b;
      e = exp_ms(k, n, iv, bd);
      @(posedge sys_clk);
      resp_interval <= 7'(iv);
      baud_sel <= 3'(bd);
      send(3, bc, 0, 3);
      wait_for(6);
      ropen = 1'b0;
      pulse(k, n, bc, 1'b0);
      if (bc) begin
         wait_for(0);
         chk(16'(ropen), 16'h0000);
         chk_rng(cyc - t_h, e * 100, 60000);
         return;
      end
      wait_for(1);
      chk_rng(cyc - t_h, e * 100 - 2, e * 100 + 110);
      for (int j = 0; j < 3; j++) begin
         b = 8'($urandom);
         rsp_q.push_back(b);
         @(posedge sys_clk);
         tx_valid <= 1'b1;
         tx_data <= b;
         tx_last <= (j == 2);
         wait_for(2);
         @(posedge sys_clk);
         tx_valid <= 1'b0;
      end
      wait_for(3);
      chk(16'(retry_cnt), 16'h0000);
   endtask : rsp_case

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      rx_ready <= rdy_en;
      n_ovr <= n_ovr + int'(fifo_overrun === 1'b1);
      n_drop <= n_drop + int'(frame_drop === 1'b1);
      if (resp_open === 1'b1) ropen <= 1'b1;
      if (rsft_link_if_inst.h2d_stb === 1'b1) t_h <= cyc;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) chk(16'({rx_first, rx_data}), 16'(exp_q.pop_front()));
      if (rsp_valid === 1'b1) chk(16'(rsp_data), 16'(rsp_q.pop_front()));
   end

   initial begin
      {rstn, frame_ok, frame_bcast, frame_other, tx_valid, tx_last, cmd_valid} = '0;
      {cmd_last, cmd_bcast, frame_kind, frame_words, tx_data, cmd_data, rx_ready} = '0;
      {rdy_en, ropen} = 2'h2;
      baud_sel = 3'h4;
      resp_interval = 7'h00;
      // Host timeout stays above the slowest device answer these cases ask for (500 ms)
      timeout_ms = 13'h3E8;
      bcast_wait_ms = 13'h03C;
      void'($urandom(32'h688CB41E));
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      rsp_case(0, 1 + $urandom_range(15), 0, 1'b0, 4);
      rsp_case(0, 1, 0, 1'b0, 0);
      rsp_case(1, 1 + $urandom_range(2), $urandom_range(3), 1'b0, 4);
      rsp_case(2, 1, 0, 1'b0, 4);
      rsp_case(2, 1, 3, 1'b0, 4);
      rsp_case(4, 1, 0, 1'b0, 4);
      rsp_case(1, 1, 0, 1'b1, 4);
      @(posedge sys_clk);
      timeout_ms <= 13'h002;
      ropen = 1'b0;
      // Unanswered frames: split, overflowing, for another station, dropped
      for (int k = 0; k < 4; k++) begin
         rdy_en = (k != 1);
         send((k == 1) ? 6 : 2, 1'b0, (k == 0) ? 1 : 0, (k == 1) ? 4 : 2);
         // Frame end only after the last byte has landed, else it is cut short
         if (k == 2) begin
            wait_for(6);
            pulse(0, 1, 1'b0, 1'b1);
         end
         @(negedge sys_clk);
         chk(16'(cmd_ready), 16'h0000);
         wait_for(4);
         @(negedge sys_clk);
         chk(16'(retry_cnt), 16'(k + 1));
         chk(16'(fault), 16'(k == 3));
         rdy_en = 1'b1;
         wait_for(6);
      end
      chk(16'(n_ovr), 16'h0002);
      chk(16'(n_drop), 16'h0004);
      chk(16'(ropen), 16'h0000);
      print_verdict();
   end
endmodule : test_rtu_slave_frame_timing
`default_nettype wire
